// [hw/gpa_port.sv]
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/100ps
// Overview of operation
// RULE1: Direction bit 1 drives pin, 0 inputs
// RULE2: Reset leaves pins input except address pin
// RULE3: Direction clears to zero in other modes
// RULE4: Modes 3/4: direction 0x80, top fixed
// RULE5: Direction register write-only, reads all ones
// RULE6: Software standby keeps direction contents
// RULE7: Data latch holds values driven on outputs
// RULE8: Output pins read back latch bit
// RULE9: Input pins read back pin level
// RULE10: Data latch clears on reset, standby
// RULE11: Pattern outputs need direction bit set
// RULE12: Unclaimed pins remain general purpose
// RULE13: Peripheral claim overrides direction and data
module gpa_port
  import gpa_pkg::*;
#(
  parameter int unsigned WIDTH = 8  // Pins in the port
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // System control
  input  wire logic [2:0]          mode_i,
  input  wire logic                hw_standby_i,
  // Wishbone slave
  input  wire gpa_pkg::gpa_wb_req_t wb_req_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Alternate functions
  input  wire gpa_pkg::gpa_alt_t   alt_i,
  input  wire logic [WIDTH-1:0]    pattern_out_i,
  input  wire logic [WIDTH-1:0]    pattern_en_i,
  input  wire logic                addr_bit_twenty_i,
  // Pins
  input  wire logic [WIDTH-1:0]    pin_i,
  output logic      [WIDTH-1:0]    pin_o,
  output logic      [WIDTH-1:0]    pin_oe_o,
  // Settled pin levels for peripherals
  output logic      [WIDTH-1:0]    pin_level_o
);

  import gpa_pkg::*;

  // Register state
  logic [WIDTH-1:0] dir_ff;       // direction_control
  logic [WIDTH-1:0] latch_ff;     // output_data_latch
  // Bus answer
  logic             ack_ff;       // Acknowledge, one cycle
  logic [31:0]      dat_ff;       // Read data
  // Pin drivers
  logic [WIDTH-1:0] pin_out_ff;   // Driven level
  logic [WIDTH-1:0] pin_oe_ff;    // Drive enable
  logic [WIDTH-1:0] level_ff;     // Settled levels to peripherals
  // Combinational terms
  logic [WIDTH-1:0] pin_sync;     // Synchronised pin levels
  logic             addr_mode;    // Top pin carries address bit
  logic             req;          // Bus request present
  logic             hit_dir;      // Address decodes direction
  logic             hit_latch;    // Address decodes latch
  logic             wr_dir;       // Direction write takes effect
  logic             wr_latch;     // Latch write takes effect
  logic             clr;          // Reset or hardware standby
  logic [31:0]      nxt_dat;      // Read mux
  logic [WIDTH-1:0] nxt_pin_out;  // Next driven level
  logic [WIDTH-1:0] nxt_pin_oe;   // Next drive enable
  logic [WIDTH-1:0] wr_byte;      // Low data lane of a write
  logic [WIDTH-1:0] pat_undir;    // Pattern pins lacking direction

  // Pin input synchroniser
  gpa_pin_sync #(
    .WIDTH (WIDTH)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (pin_i),
    .level_o (pin_sync)
  );

  // Mode and clear qualifiers
  assign addr_mode = gpa_addr_mode(mode_i);
  assign clr       = rst_i || hw_standby_i;

  // Address decode on word index; low two bits ignored
  assign req       = wb_req_i.cyc && wb_req_i.stb;
  assign hit_dir   = wb_req_i.adr[GPA_ADR_W-1:2] == GPA_DIR_IDX;
  assign hit_latch = wb_req_i.adr[GPA_ADR_W-1:2] == GPA_LATCH_IDX;

  // Writes land on the edge where the master sees ack, low lane only
  assign wr_dir   = req && ack_ff && wb_req_i.we && wb_req_i.sel[0]
                    && hit_dir;
  assign wr_latch = req && ack_ff && wb_req_i.we && wb_req_i.sel[0]
                    && hit_latch;

  // Data lane that a write stores; one place for both registers
  assign wr_byte = wb_req_i.dat[WIDTH-1:0];

  // Pattern pins whose direction bit software left clear
  assign pat_undir = pattern_en_i & ~alt_i.own & ~dir_ff;

  // Read mux; unmapped reads return zero
  always_comb begin
    nxt_dat = 32'h0000_0000;
    if (hit_dir) begin
      // Stored value never visible
      nxt_dat[WIDTH-1:0] = GPA_DIR_READBACK; // RULE5
    end else if (hit_latch) begin
      // Outputs show the latch, inputs show the pin
      nxt_dat[WIDTH-1:0] = (dir_ff & latch_ff)       // RULE8
                         | (~dir_ff & pin_sync);     // RULE9
    end
  end

  // Acknowledge one cycle after the request, drop right after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req && !ack_ff;
    end
  end

  // Read data sampled with the ack, zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= 32'h0000_0000;
    end else if (req && !ack_ff && !wb_req_i.we) begin
      dat_ff <= nxt_dat;
    end else begin
      dat_ff <= 32'h0000_0000;
    end
  end

  // Direction register; only clear or a write changes it, so
  // software standby leaves it alone
  always_ff @(posedge clk_i) begin
    if (clr) begin
      dir_ff <= gpa_dir_reset(mode_i); // RULE3 RULE4
    end else if (wr_dir) begin
      dir_ff <= wr_byte; // RULE6
      if (addr_mode) begin
        // Top bit cannot be cleared while address pin is dedicated
        dir_ff[GPA_TOP_PIN] <= 1'b1; // RULE4
      end
    end
  end

  // Output data latch; mode does not affect its clear value
  always_ff @(posedge clk_i) begin
    if (clr) begin
      latch_ff <= GPA_LATCH_RST; // RULE10
    end else if (wr_latch) begin
      latch_ff <= wr_byte; // RULE7
    end
  end

  // Pin ownership priority: address bit, peripheral, pattern,
  // then general purpose
  always_comb begin
    nxt_pin_out = '0;
    nxt_pin_oe  = '0;
    for (int i = 0; i < WIDTH; i++) begin
      if (addr_mode && (i == GPA_TOP_PIN)) begin
        // Dedicated address output
        nxt_pin_out[i] = addr_bit_twenty_i; // RULE4
        nxt_pin_oe[i]  = 1'b1;              // RULE2
      end else if (alt_i.own[i]) begin
        // Peripheral wins over direction and latch
        nxt_pin_out[i] = alt_i.out[i]; // RULE13
        nxt_pin_oe[i]  = alt_i.oe[i];  // RULE13
      end else if (pattern_en_i[i]) begin
        // Pattern drives only where software set the direction bit
        nxt_pin_out[i] = pattern_out_i[i]; // RULE11
        nxt_pin_oe[i]  = dir_ff[i];        // RULE11
      end else begin
        // General purpose pin
        nxt_pin_out[i] = latch_ff[i]; // RULE7 RULE12
        nxt_pin_oe[i]  = dir_ff[i];   // RULE1 RULE12
      end
    end
  end

  // Pin driver registers; reset gives inputs except address pin
  always_ff @(posedge clk_i) begin
    if (clr) begin
      pin_out_ff <= '0;
      pin_oe_ff  <= gpa_dir_reset(mode_i); // RULE2
      if (addr_mode) begin
        // Address pin follows the address bit through a clear, so it never
        // shows a false address while dedicated
        pin_out_ff[GPA_TOP_PIN] <= addr_bit_twenty_i; // RULE4
      end
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff  <= nxt_pin_oe;
    end
  end

  // Settled levels for peripheral inputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_ff <= '0;
    end else begin
      level_ff <= pin_sync;
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack_o    = ack_ff;
  assign wb_dat_o    = dat_ff;
  assign pin_o       = pin_out_ff;
  assign pin_oe_o    = pin_oe_ff;
  assign pin_level_o = level_ff;

  // ---------------- Assertions ----------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Bus handshake steps
  sequence req_fresh_s;
    req && !ack_ff;
  endsequence
  sequence ack_pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  // Request answered next cycle for one cycle only
  bus_handshake_a: assert property (req_fresh_s |=> ack_pulse_s)
    else $error("ack not a single pulse after request");

  // Plain pin follows its direction bit
  gpio_direction_a: assert property ( // RULE1
    !addr_mode && !hw_standby_i && (alt_i.own == '0)
    && (pattern_en_i == '0) |=> pin_oe_o == $past(dir_ff))
    else $error("pin enable does not follow direction");

  // Cleared direction register in normal modes
  dir_clear_a: assert property ( // RULE3
    hw_standby_i && !addr_mode |=> dir_ff == GPA_DIR_RST_NORMAL)
    else $error("direction not cleared in normal mode");

  // Address pin dedicated in modes 3 and 4
  top_fixed_a: assert property ( // RULE4
    addr_mode && $stable(mode_i) |=> dir_ff[GPA_TOP_PIN]
    && pin_oe_o[GPA_TOP_PIN] ##0
    pin_o[GPA_TOP_PIN] == $past(addr_bit_twenty_i))
    else $error("top pin not carrying address bit");

  // Standby keeps pins input except the address pin
  standby_input_a: assert property ( // RULE2
    hw_standby_i && !addr_mode |=> pin_oe_o == '0)
    else $error("pin driven after hardware standby");

  // Direction reads as all ones
  dir_read_a: assert property ( // RULE5
    req_fresh_s and !wb_req_i.we && hit_dir
    |=> wb_dat_o == 32'h0000_00FF)
    else $error("direction readback not all ones");

  // Direction changes only through clear or write
  dir_hold_a: assert property ( // RULE6
    !wr_dir && !hw_standby_i |=> $stable(dir_ff))
    else $error("direction changed without a write");

  // Data read mixes latch and pin by direction
  data_read_a: assert property ( // RULE8
    req_fresh_s and !wb_req_i.we && hit_latch |=>
    wb_dat_o[WIDTH-1:0] == (($past(dir_ff) & $past(latch_ff))
    | (~$past(dir_ff) & $past(pin_sync))))
    else $error("data readback wrong");

  // Latch clears on hardware standby in any mode
  latch_clear_a: assert property ( // RULE10
    hw_standby_i |=> latch_ff == GPA_LATCH_RST)
    else $error("latch not cleared by standby");

  // Pattern output gated by direction bit
  pattern_gate_a: assert property ( // RULE11
    !addr_mode && !hw_standby_i && (pat_undir != '0)
    |=> (pin_oe_o & $past(pat_undir)) == '0)
    else $error("pattern driven without direction bit");

  // Peripheral claim overrides the port
  alt_override_a: assert property ( // RULE13
    alt_i.own[0] && !hw_standby_i |=> pin_o[0] == $past(alt_i.out[0])
    && pin_oe_o[0] == $past(alt_i.oe[0]))
    else $error("peripheral claim not honoured");

  // Latch write stores the low data lane
  latch_write_a: assert property ( // RULE7
    wr_latch && !hw_standby_i |=> latch_ff == $past(wr_byte))
    else $error("latch write lost");

  // Latch keeps its value between writes and clears
  latch_hold_a: assert property ( // RULE10
    !wr_latch && !hw_standby_i |=> $stable(latch_ff))
    else $error("latch changed without a write");

  // Direction write stores the low data lane outside address modes
  dir_write_a: assert property ( // RULE1
    wr_dir && !hw_standby_i && !addr_mode |=> dir_ff == $past(wr_byte))
    else $error("direction write lost");

  // Read data stands only in the ack cycle
  dat_idle_a: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack cycle");

endmodule : gpa_port

// [hw/gpa_pkg.sv]
package gpa_pkg;

  // Port geometry
  localparam int unsigned GPA_WIDTH     = 8;   // Pins in the port
  localparam int unsigned GPA_TOP_PIN   = 7;   // Pin that can carry the address bit
  localparam int unsigned GPA_ADR_W     = 22;  // Wishbone byte address width
  localparam int unsigned GPA_IDX_W     = 20;  // Register index width

  // Register indices; byte address is four times the index
  localparam logic [19:0] GPA_DIR_IDX   = 20'hEE009; // direction_control
  localparam logic [19:0] GPA_LATCH_IDX = 20'hFFFD9; // output_data_latch

  // Reset values
  localparam logic [7:0]  GPA_DIR_RST_NORMAL = 8'h00; // Modes 1, 2, 5, 6, 7
  localparam logic [7:0]  GPA_DIR_RST_ADDR   = 8'h80; // Modes 3, 4
  localparam logic [7:0]  GPA_LATCH_RST      = 8'h00; // Every mode
  localparam logic [7:0]  GPA_DIR_READBACK   = 8'hFF; // Write-only read value

  // Operating modes that dedicate the top pin to the address bit
  localparam logic [2:0]  GPA_MODE_THREE = 3'h3;
  localparam logic [2:0]  GPA_MODE_FOUR  = 3'h4;

  // Synchroniser depth for pin inputs
  localparam int unsigned GPA_SYNC_STAGES = 3;

  // Wishbone request from the master
  typedef struct packed {
    logic                 cyc;
    logic                 stb;
    logic                 we;
    logic [GPA_ADR_W-1:0] adr;
    logic [3:0]           sel;
    logic [31:0]          dat;
  } gpa_wb_req_t;

  // Alternate peripheral claim on the pins
  typedef struct packed {
    logic [GPA_WIDTH-1:0] own; // Peripheral owns the pin
    logic [GPA_WIDTH-1:0] out; // Peripheral output level
    logic [GPA_WIDTH-1:0] oe;  // Peripheral drive enable
  } gpa_alt_t;

  // True in the modes that force the top pin to the address bit
  function automatic logic gpa_addr_mode(input logic [2:0] mode);
    gpa_addr_mode = (mode == GPA_MODE_THREE) || (mode == GPA_MODE_FOUR);
  endfunction : gpa_addr_mode

  // Direction register value after reset for a mode
  function automatic logic [7:0] gpa_dir_reset(input logic [2:0] mode);
    gpa_dir_reset = gpa_addr_mode(mode) ? GPA_DIR_RST_ADDR
                                        : GPA_DIR_RST_NORMAL;
  endfunction : gpa_dir_reset

endpackage : gpa_pkg

// [hw/gpa_pin_sync.sv]
`timescale 1ns/100ps
module gpa_pin_sync #(
  parameter int unsigned WIDTH = 8  // Bits to synchronise
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Asynchronous levels in, settled levels out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o
);

  // Three stage chain; first stage feeds only the second
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] level_ff;   // Accepted level

  // Shift chain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
      stage3_ff <= '0;
    end else begin
      stage1_ff <= async_i;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
    end
  end

  // Accept a change only once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_ff <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_ff[i] == stage3_ff[i]) begin
          level_ff[i] <= stage3_ff[i];
        end
      end
    end
  end

  assign level_o = level_ff;

endmodule : gpa_pin_sync

// [verification/gpa_pin_model.sv]
`timescale 1ns/100ps
// Board side of the port: a pin shows the port's level while the port
// drives it, otherwise the level applied from outside
module gpa_pin_model
  import gpa_pkg::*;
(
  // Port side
  input  wire logic [GPA_WIDTH-1:0] drv_i,
  input  wire logic [GPA_WIDTH-1:0] drv_en_i,
  // Outside level; changed only in the reset and direction tests
  input  wire logic [GPA_WIDTH-1:0] ext_i,
  // Resolved wire
  output logic      [GPA_WIDTH-1:0] pin_i
);
  // Per-pin resolution, no keeper
  always_comb begin
    for (int b = 0; b < GPA_WIDTH; b++) begin
      pin_i[b] = drv_en_i[b] ? drv_i[b] : ext_i[b];
    end
  end
endmodule : gpa_pin_model

// [verification/tb.sv]
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb;
  import gpa_pkg::*;
  localparam logic [21:0] DIR_ADR = {GPA_DIR_IDX, 2'b00};
  localparam logic [21:0] LAT_ADR = {GPA_LATCH_IDX, 2'b00};
  localparam logic [21:0] BAD_ADR = 22'h000010; // Unmapped
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [2:0]  mode_i = 3'h1;
  logic        hw_standby_i = 1'b0;
  gpa_wb_req_t wb_req_i = '0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  gpa_alt_t    alt_i = '0;
  logic [7:0]  pattern_out_i = 8'h00;
  logic [7:0]  pattern_en_i = 8'h00;
  logic        addr_bit_twenty_i = 1'b0;
  logic [7:0]  pin_i;
  logic [7:0]  pin_o;
  logic [7:0]  pin_oe_o;
  logic [7:0]  pin_level_o;
  logic [7:0]  ext = 8'h00;        // Outside pin levels
  logic [31:0] exp_v;              // Note taken off the queue
  logic [7:0]  d;                  // Latch value written
  logic [7:0]  m;                  // Direction value written
  logic [7:0]  p;                  // Pattern value
  logic [31:0] exp_q[$];           // Expected read data, oldest first
  int          err_total = 0;
  int          n_tests = 0;

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  gpa_port #(.WIDTH(GPA_WIDTH)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i),
    .hw_standby_i(hw_standby_i), .wb_req_i(wb_req_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .alt_i(alt_i),
    .pattern_out_i(pattern_out_i), .pattern_en_i(pattern_en_i),
    .addr_bit_twenty_i(addr_bit_twenty_i), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pin_level_o(pin_level_o));

  gpa_pin_model u_pins (
    .drv_i(pin_o), .drv_en_i(pin_oe_o), .ext_i(ext), .pin_i(pin_i));

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // One classic cycle; writes expect zero data in the ack cycle
  task automatic wb(input logic we, input logic [21:0] a,
                    input logic [7:0] wd, input logic [7:0] e);
    int n;
    n = 0;
    exp_q.push_back(we ? 32'h0 : {24'h0, e});
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF,
                  dat: {24'h0, wd}};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("[FAIL] %0t no ack", $time);
    end
    wb_req_i <= '0;
    @(posedge clk_i);
  endtask : wb

  // Reset with a mode held stable
  task automatic rst_dut(input logic [2:0] md);
    mode_i <= md;
    rst_i  <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : rst_dut

  // Settle time for pin synchroniser and registered outputs
  task automatic settle();
    repeat (6) @(posedge clk_i);
  endtask : settle

  // Read data watcher: every ack retires the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("[FAIL] %0t got %h exp none", $time, wb_dat_o);
      end else begin
        exp_v = exp_q.pop_front();
        `CHK(wb_dat_o, exp_v)
      end
    end
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #(40 * 5000);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    void'($urandom(32'hCFE2));
    rst_dut(3'h1);
    // Reset state: inputs, direction reads as ones
    ext <= 8'($urandom);
    settle();
    `CHK(pin_oe_o, 8'h00)
    `CHK(pin_level_o, ext)
    wb(1'b0, DIR_ADR, 8'h00, GPA_DIR_READBACK);
    wb(1'b0, LAT_ADR, 8'h00, ext);
    wb(1'b0, BAD_ADR, 8'h00, 8'h00);
    $display("reset test done");
    // Random directions and data, mixed read back
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      m = 8'($urandom);
      wb(1'b1, LAT_ADR, d, 8'h00);
      wb(1'b1, DIR_ADR, m, 8'h00);
      ext <= 8'($urandom);
      settle();
      `CHK(pin_oe_o, m)
      `CHK(pin_o & m, d & m)
      `CHK(pin_level_o, (d & m) | (ext & ~m))
      wb(1'b0, LAT_ADR, 8'h00, (d & m) | (ext & ~m));
    end
    $display("direction test done");
    // Pattern needs direction; peripheral claim wins
    p = 8'($urandom);
    wb(1'b1, DIR_ADR, 8'h0F, 8'h00);
    pattern_en_i  <= 8'h33;
    pattern_out_i <= p;
    settle();
    `CHK(pin_oe_o, 8'h0F)
    `CHK(pin_o & 8'h0F, (p & 8'h03) | (d & 8'h0C))
    alt_i <= '{own: 8'h81, out: 8'h01, oe: 8'h81};
    settle();
    `CHK(pin_oe_o, 8'h8F)
    `CHK(pin_o & 8'h8F, 8'h01 | (p & 8'h02) | (d & 8'h0C))
    alt_i        <= '0;
    pattern_en_i <= 8'h00;
    $display("alternate test done");
    // Hardware standby clears both registers
    hw_standby_i <= 1'b1;
    @(posedge clk_i);
    hw_standby_i <= 1'b0;
    settle();
    `CHK(pin_oe_o, 8'h00)
    wb(1'b1, DIR_ADR, 8'hFF, 8'h00);
    settle();
    `CHK(pin_o, GPA_LATCH_RST)
    wb(1'b1, LAT_ADR, 8'h5A, 8'h00);
    repeat (20) @(posedge clk_i);
    wb(1'b0, LAT_ADR, 8'h00, 8'h5A);
    $display("standby test done");
    // Every mode: reset direction, top pin in address modes
    for (int k = 1; k <= 7; k++) begin
      addr_bit_twenty_i <= 1'b1;
      rst_dut(k[2:0]);
      settle();
      `CHK(pin_oe_o, (k == 3 || k == 4) ? 8'h80 : 8'h00)
      if (k == 3 || k == 4) begin
        `CHK(pin_o[7], 1'b1)
        wb(1'b1, DIR_ADR, 8'h01, 8'h00);
        settle();
        `CHK(pin_oe_o, 8'h81)
        wb(1'b0, LAT_ADR, 8'h00, ext & 8'h7E);
      end
    end
    $display("mode test done");
    complete_run();
  end
endmodule : tb
